// ===== design/nrs_pkg.sv
// Package of command codes, pin groups and timing counts for the flash host sequencer
package nrs_pkg;
    localparam logic [7:0] CMD_READ_SETUP   = 8'h00;
    localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
    localparam logic [7:0] CMD_CACHE_READ   = 8'h31;
    localparam logic [7:0] CMD_CACHE_LAST   = 8'h3F;
    localparam logic [7:0] CMD_ROW_SETUP    = 8'h60;
    localparam logic [7:0] CMD_DATA_INPUT   = 8'h80;
    localparam logic [7:0] CMD_DATA_INPUT2  = 8'h81;
    localparam logic [7:0] CMD_COL_CHANGE   = 8'h85;
    localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
    localparam logic [7:0] CMD_PROG_FIRST   = 8'h11;
    localparam logic [7:0] CMD_STATUS       = 8'h70;
    localparam logic [7:0] CMD_RESET        = 8'hFF;
    // Address layout
    localparam int COL_BITS  = 13;
    localparam int ROW_BITS  = 18;
    localparam int PAGE_BITS = 6;
    localparam int STATUS_FAIL_BIT = 0;
    // Strobe phase length: 100 ns at 10 MHz, at least one cycle
    localparam int CLK_NS      = 100;
    localparam int STROBE_NS   = 100;
    localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
    localparam logic [3:0] CNT_ZERO = 4'h0;

    // Operations the user may start
    typedef enum logic [2:0] {
        OP_READ, OP_CACHE_NEXT, OP_CACHE_LAST, OP_DUAL_READ,
        OP_PROGRAM, OP_DUAL_PROGRAM, OP_STATUS, OP_RESET
    } nrs_op_type;

    typedef struct packed {
        logic                 cle;
        logic                 ale;
        logic                 writeStrobeN;
        logic                 outputStrobeN;
        logic                 chipEnableN;
        logic                 writeProtectN;
        logic [7:0]           dataOut;
        logic                 dataOe;
    } nrs_pins_type;

    typedef struct packed {
        nrs_op_type           op;
        logic [COL_BITS-1:0]  columnAddr;
        logic [ROW_BITS-1:0]  rowAddr;
        logic [ROW_BITS-1:0]  rowAddr2;
    } nrs_req_type;
endpackage

// ===== design/nrs_host.sv
// Host sequencer that drives a two-district flash through its latch, strobe and data pins
`timescale 1ns/1ps
module nrs_host
    import nrs_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   resetn,
    input  wire logic                   clockEnable,
    input  wire nrs_pkg::nrs_req_type   req,
    input  wire logic                   reqValid,
    output logic                        reqReady,
    input  wire logic [7:0]             wrData,
    input  wire logic                   wrValid,
    output logic                        wrReady,
    input  wire logic [15:0]            byteCount,
    output logic [7:0]                  rdData,
    output logic                        rdValid,
    output logic                        failFlag,
    output logic                        done,
    output nrs_pkg::nrs_pins_type       pins,
    input  wire logic [7:0]             dataIn,
    input  wire logic                   readyBusyN
);
    import nrs_pkg::*;

    typedef enum {
        S_IDLE, S_CMD, S_ADDR, S_WAIT_RB, S_DATA_WR, S_DATA_RD, S_NEXT, S_DONE
    } nrs_state_type;

    // Step list entries: command or address bytes with what follows them
    nrs_state_type state_reg;
    nrs_req_type   req_reg;
    logic [3:0]    step_reg;
    logic [2:0]    addrIdx_reg;
    logic [3:0]    cnt_reg;
    logic          phase_reg;
    logic [15:0]   left_reg;
    logic [7:0]    cmd_reg;
    logic          statusMode_reg;
    logic [ROW_BITS-PAGE_BITS-1:0] cacheBlock_reg;

    // Byte of the five-cycle address; column first, upper column bits low
    function automatic logic [7:0] addrByte(input logic [COL_BITS-1:0] c, input logic [ROW_BITS-1:0] r,
                                            input logic [2:0] i);
        case (i)
            3'h0:    addrByte = c[7:0];
            3'h1:    addrByte = {3'h0, c[12:8]};
            3'h2:    addrByte = r[7:0];
            3'h3:    addrByte = r[15:8];
            3'h4:    addrByte = {6'h00, r[17:16]};
            default: addrByte = 8'h00;
        endcase
    endfunction

    // Command of each step of the chosen operation; 8'h00 with step>0 never used
    function automatic logic [7:0] stepCmd(input nrs_op_type op, input logic [3:0] s);
        case (op)
            OP_READ:         stepCmd = (s == 4'h0) ? CMD_READ_SETUP : CMD_READ_CONFIRM;
            OP_CACHE_NEXT:   stepCmd = CMD_CACHE_READ;
            OP_CACHE_LAST:   stepCmd = CMD_CACHE_LAST;
            OP_DUAL_READ:    stepCmd = (s == 4'h2) ? CMD_READ_CONFIRM : CMD_ROW_SETUP;
            OP_PROGRAM:      stepCmd = (s == 4'h0) ? CMD_DATA_INPUT : CMD_PROG_CONFIRM;
            OP_DUAL_PROGRAM: stepCmd = (s == 4'h0) ? CMD_DATA_INPUT : (s == 4'h1) ? CMD_PROG_FIRST :
                                       (s == 4'h2) ? CMD_DATA_INPUT2 : CMD_PROG_CONFIRM;
            OP_STATUS:       stepCmd = CMD_STATUS;
            default:         stepCmd = CMD_RESET;
        endcase
    endfunction

    wire logic [7:0] curCmd = stepCmd(req_reg.op, step_reg);
    wire logic       phaseEnd = (cnt_reg == CNT_ZERO);
    // Addresses follow setup/row/data-input commands; row bytes only for row setup
    wire logic       needAddr = (cmd_reg == CMD_READ_SETUP) || (cmd_reg == CMD_ROW_SETUP) ||
                                (cmd_reg == CMD_DATA_INPUT) || (cmd_reg == CMD_DATA_INPUT2);
    wire logic       secondRow = (req_reg.op == OP_DUAL_READ || req_reg.op == OP_DUAL_PROGRAM) && step_reg >= 4'h1;
    // Second district takes the page bits of the first, so both pages always match
    wire logic [ROW_BITS-1:0] rowSel = secondRow ? {req_reg.rowAddr2[ROW_BITS-1:PAGE_BITS],
                                                    req_reg.rowAddr[PAGE_BITS-1:0]} : req_reg.rowAddr;
    wire logic [2:0] firstAddr = (cmd_reg == CMD_ROW_SETUP) ? 3'h2 : 3'h0;
    wire logic       busyCmd = (cmd_reg == CMD_READ_CONFIRM) || (cmd_reg == CMD_CACHE_READ) ||
                               (cmd_reg == CMD_CACHE_LAST) || (cmd_reg == CMD_PROG_CONFIRM) ||
                               (cmd_reg == CMD_PROG_FIRST) || (cmd_reg == CMD_RESET);
    // Status also ends in a byte read, or failFlag would never be refreshed
    wire logic       readOut = (req_reg.op == OP_READ || req_reg.op == OP_DUAL_READ ||
                                req_reg.op == OP_CACHE_NEXT || req_reg.op == OP_CACHE_LAST || req_reg.op == OP_STATUS);
    wire logic       lastStep = (req_reg.op == OP_READ || req_reg.op == OP_PROGRAM) ? (step_reg == 4'h1) :
                                (req_reg.op == OP_DUAL_READ) ? (step_reg == 4'h2) :
                                (req_reg.op == OP_DUAL_PROGRAM) ? (step_reg == 4'h3) : 1'b1;
    // A cached step on another block cannot reuse the page buffer; it restarts as a plain read
    wire logic       cacheRestart = (req.op == OP_CACHE_NEXT || req.op == OP_CACHE_LAST) &&
                                    (req.rowAddr[ROW_BITS-1:PAGE_BITS] != cacheBlock_reg);

    // Sequencer: each pin cycle is a low phase then a high phase of the strobe
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg      <= S_IDLE;
            req_reg        <= '0;
            step_reg       <= 4'h0;
            addrIdx_reg    <= 3'h0;
            cnt_reg        <= CNT_ZERO;
            phase_reg      <= 1'b0;
            left_reg       <= 16'h0000;
            cmd_reg        <= CMD_RESET;
            statusMode_reg <= 1'b0;
            cacheBlock_reg <= '0;
            reqReady       <= 1'b1;
            wrReady        <= 1'b0;
            rdData         <= 8'h00;
            rdValid        <= 1'b0;
            failFlag       <= 1'b0;
            done           <= 1'b0;
            pins           <= '{cle: 1'b0, ale: 1'b0, writeStrobeN: 1'b1, outputStrobeN: 1'b1,
                                chipEnableN: 1'b1, writeProtectN: 1'b1, dataOut: 8'h00, dataOe: 1'b0};
        end else if (clockEnable) begin
            rdValid <= 1'b0;
            done    <= 1'b0;
            wrReady <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    pins.chipEnableN <= 1'b1;
                    // Only begin once the flash reports ready, except status and reset
                    if (reqValid && (readyBusyN || req.op == OP_STATUS || req.op == OP_RESET)) begin
                        req_reg          <= req;
                        req_reg.op       <= cacheRestart ? OP_READ : req.op;
                        cacheBlock_reg   <= req.rowAddr[ROW_BITS-1:PAGE_BITS];
                        step_reg         <= 4'h0;
                        reqReady         <= 1'b0;
                        left_reg         <= byteCount;
                        pins.chipEnableN <= 1'b0;
                        pins.writeProtectN <= 1'b1;
                        state_reg        <= S_CMD;
                    end
                end
                S_CMD: begin
                    // Command byte with command latch high, taken on the rising strobe
                    if (!phase_reg) begin
                        cmd_reg           <= curCmd;
                        pins.cle          <= 1'b1;
                        pins.ale          <= 1'b0;
                        pins.dataOut      <= curCmd;
                        pins.dataOe       <= 1'b1;
                        pins.writeStrobeN <= 1'b0;
                        phase_reg         <= 1'b1;
                        cnt_reg           <= STROBE_CNT - 4'h1;
                    end else if (pins.writeStrobeN == 1'b0) begin
                        if (phaseEnd) begin
                            pins.writeStrobeN <= 1'b1;
                            cnt_reg           <= STROBE_CNT - 4'h1;
                        end else begin
                            cnt_reg <= cnt_reg - 4'h1;
                        end
                    end else if (phaseEnd) begin
                        pins.cle    <= 1'b0;
                        phase_reg   <= 1'b0;
                        statusMode_reg <= (cmd_reg == CMD_STATUS);
                        if (needAddr) begin
                            addrIdx_reg <= firstAddr;
                            state_reg   <= S_ADDR;
                        end else if (busyCmd) begin
                            state_reg <= S_WAIT_RB;
                        end else begin
                            state_reg <= S_NEXT;
                        end
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                S_ADDR: begin
                    // Five address cycles (three row bytes for row setup), column bytes then row bytes
                    if (!phase_reg) begin
                        pins.ale          <= 1'b1;
                        pins.dataOut      <= addrByte(req_reg.columnAddr, rowSel, addrIdx_reg);
                        pins.dataOe       <= 1'b1;
                        pins.writeStrobeN <= 1'b0;
                        phase_reg         <= 1'b1;
                    end else if (!pins.writeStrobeN) begin
                        pins.writeStrobeN <= 1'b1;
                    end else begin
                        phase_reg <= 1'b0;
                        if (addrIdx_reg == 3'h4) begin
                            pins.ale <= 1'b0;
                            state_reg <= (cmd_reg == CMD_DATA_INPUT || cmd_reg == CMD_DATA_INPUT2) ?
                                         S_DATA_WR : S_NEXT;
                        end else begin
                            addrIdx_reg <= addrIdx_reg + 3'h1;
                        end
                    end
                end
                S_WAIT_RB: begin
                    // Busy after confirm; on ready the next step follows at once, with no status read between districts
                    pins.dataOe <= 1'b0;
                    if (readyBusyN && !pins.cle) begin
                        state_reg <= lastStep ? (readOut ? S_DATA_RD : S_DONE) : S_NEXT;
                    end
                end
                S_DATA_WR: begin
                    // Page data bytes; back-pressure through wrReady
                    if (left_reg == 16'h0000) begin
                        state_reg <= S_NEXT;
                    end else if (!phase_reg) begin
                        wrReady <= 1'b1;
                        if (wrValid && wrReady) begin
                            wrReady           <= 1'b0;
                            pins.dataOut      <= wrData;
                            pins.dataOe       <= 1'b1;
                            pins.writeStrobeN <= 1'b0;
                            phase_reg         <= 1'b1;
                        end
                    end else begin
                        pins.writeStrobeN <= 1'b1;
                        phase_reg         <= 1'b0;
                        left_reg          <= left_reg - 16'h0001;
                    end
                end
                S_DATA_RD: begin
                    // Each falling output strobe gives the next byte, sampled before rising
                    pins.dataOe <= 1'b0;
                    if (left_reg == 16'h0000) begin
                        state_reg <= S_DONE;
                    end else if (!phase_reg) begin
                        pins.outputStrobeN <= 1'b0;
                        phase_reg          <= 1'b1;
                    end else begin
                        rdData             <= dataIn;
                        rdValid            <= 1'b1;
                        pins.outputStrobeN <= 1'b1;
                        phase_reg          <= 1'b0;
                        left_reg           <= left_reg - 16'h0001;
                        if (statusMode_reg) begin
                            failFlag <= dataIn[STATUS_FAIL_BIT];
                        end
                    end
                end
                S_NEXT: begin
                    step_reg  <= step_reg + 4'h1;
                    left_reg  <= byteCount;
                    state_reg <= lastStep ? (readOut ? S_DATA_RD : S_DONE) : S_CMD;
                end
                S_DONE: begin
                    done             <= 1'b1;
                    reqReady         <= 1'b1;
                    pins.chipEnableN <= 1'b1;
                    state_reg        <= S_IDLE;
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // Status op reads one byte; setting byteCount to 1 is the user's task
    a_strobe_exclusive: assert property (@(posedge clock) disable iff (!resetn)
        !(!pins.writeStrobeN && !pins.outputStrobeN)) else $error("Both strobes low");
    a_latch_exclusive: assert property (@(posedge clock) disable iff (!resetn)
        !(pins.cle && pins.ale)) else $error("Both latch selects high");
    a_read_confirm_code: assert property (@(posedge clock) disable iff (!resetn)
        (pins.cle && !pins.writeStrobeN && req_reg.op == OP_READ && step_reg == 4'h1)
        |-> pins.dataOut == CMD_READ_CONFIRM) else $error("Read confirm code wrong");
    a_addr_high_low: assert property (@(posedge clock) disable iff (!resetn)
        (pins.ale && !pins.writeStrobeN && addrIdx_reg == 3'h1) |-> pins.dataOut[7:5] == 3'h0)
        else $error("Column upper bits not low");
    a_wp_dual_read: assert property (@(posedge clock) disable iff (!resetn)
        (req_reg.op == OP_DUAL_READ && state_reg != S_IDLE) |-> pins.writeProtectN)
        else $error("Write protect low in dual read");
    a_busy_no_strobe: assert property (@(posedge clock) disable iff (!resetn)
        (state_reg == S_WAIT_RB && !readyBusyN) |=> pins.writeStrobeN && pins.outputStrobeN)
        else $error("Strobe while busy");
    a_cache_after_ready: assert property (@(posedge clock) disable iff (!resetn)
        (state_reg == S_IDLE && reqValid && reqReady && req.op == OP_CACHE_NEXT && !readyBusyN)
        |=> state_reg == S_IDLE) else $error("Cached read while busy");
    a_read_strobe_data: assert property (@(posedge clock) disable iff (!resetn)
        (state_reg == S_DATA_RD && phase_reg && clockEnable) |=> rdValid && pins.outputStrobeN)
        else $error("Read byte not delivered");
endmodule

// ===== bench/nrs_flash_model.sv
// Behavioural model of the two-district flash device as seen from its pins
`timescale 1ns/1ps
module nrs_flash_model
    import nrs_pkg::*;
#(
    parameter int BUSY_CYC = 20
)(
    input  wire logic                   clock,
    input  wire nrs_pkg::nrs_pins_type  pins,
    input  wire logic                   failInject,
    output logic [7:0]                  dataIn,
    output logic                        readyBusyN,
    output int                          protoErrs
);
    logic [7:0]  mem [int];
    logic [7:0]  pbuf [int];
    logic [7:0]  ab [5];
    logic [7:0]  cmdReg = CMD_READ_SETUP;
    logic [7:0]  dOut = 8'h00;
    logic [17:0] row = '0;
    logic [17:0] rowA = '0;
    logic [17:0] cacheRow = '0;
    logic        statusMode = 1'b0;
    logic        failBit = 1'b0;
    logic        afterFirst = 1'b0;
    int          addrIdx = 0;
    int          busyCnt = 0;
    int          col = 0;
    int          dualCnt = 0;
    wire         weN = pins.writeStrobeN;
    wire         reN = pins.outputStrobeN;

    initial protoErrs = 0;

    // Unwritten places hold a pattern made from row and column
    function automatic logic [7:0] fetch(input logic [17:0] r, input int c);
        int k;
        k = int'(r) * 8192 + c;
        return mem.exists(k) ? mem[k] : (r[7:0] ^ 8'(c) ^ 8'h5A);
    endfunction

    // Commands, addresses and data are taken on the rising write strobe
    always @(posedge weN) begin
        if (!pins.chipEnableN && pins.cle) begin
            if (busyCnt != 0 && pins.dataOut != CMD_STATUS && pins.dataOut != CMD_RESET) protoErrs++;
            if (afterFirst && !(pins.dataOut inside {CMD_DATA_INPUT2, CMD_STATUS, CMD_RESET})) protoErrs++;
            cmdReg = pins.dataOut;
            addrIdx = 0;
            statusMode = (cmdReg == CMD_STATUS);
            case (cmdReg)
                CMD_READ_CONFIRM: begin
                    if (dualCnt == 2 && (!pins.writeProtectN || rowA[6] == row[6] || rowA[5:0] != row[5:0]
                        || rowA[17] != row[17])) protoErrs++;
                    if (dualCnt == 2) col = 0;
                    cacheRow = (dualCnt == 2) ? rowA : row;
                    dualCnt = 0;
                    busyCnt = BUSY_CYC;
                end
                CMD_CACHE_READ, CMD_CACHE_LAST: begin
                    cacheRow = cacheRow + 18'h00001;
                    col = 0;
                    busyCnt = BUSY_CYC / 2;
                end
                CMD_DATA_INPUT: begin
                    pbuf.delete();
                    failBit = 1'b0;
                end
                CMD_DATA_INPUT2: afterFirst = 1'b0;
                CMD_PROG_CONFIRM, CMD_PROG_FIRST: begin
                    foreach (pbuf[k]) mem[k] = pbuf[k];
                    pbuf.delete();
                    failBit = failBit | failInject;
                    afterFirst = (cmdReg == CMD_PROG_FIRST);
                    busyCnt = afterFirst ? 2 : BUSY_CYC;
                end
                CMD_RESET: begin
                    afterFirst = 1'b0;
                    busyCnt = 2;
                end
                default: ;
            endcase
        end else if (!pins.chipEnableN && pins.ale) begin
            ab[addrIdx % 5] = pins.dataOut;
            addrIdx++;
            if (cmdReg == CMD_ROW_SETUP && addrIdx == 3) begin
                row = {ab[2][1:0], ab[1], ab[0]};
                dualCnt++;
                if (dualCnt == 1) rowA = row;
            end else if (cmdReg == CMD_COL_CHANGE && addrIdx == 2) begin
                col = {ab[1][4:0], ab[0]};
            end else if (addrIdx == 5) begin
                if (ab[1][7:5] != 3'h0 || ab[4][7:2] != 6'h00) protoErrs++;
                col = {ab[1][4:0], ab[0]};
                row = {ab[4][1:0], ab[3], ab[2]};
            end
        end else if (!pins.chipEnableN) begin
            pbuf[int'(row) * 8192 + col] = pins.dataOut;
            col++;
        end
    end

    // Each falling output strobe hands out the next byte and steps the column; status mode gives the status byte
    always @(negedge reN) begin
        if (busyCnt != 0 && !statusMode) protoErrs++;
        if (statusMode) begin
            dOut = {pins.writeProtectN, readyBusyN, readyBusyN, 4'h0, failBit};
        end else begin
            dOut = fetch(cacheRow, col);
            col++;
        end
    end

    // Busy time runs down on the system clock
    always @(posedge clock) begin
        if (busyCnt != 0) busyCnt--;
    end

    assign readyBusyN = (busyCnt == 0);
    // Released port shows the inverse of the last byte so a stale sample cannot pass
    assign dataIn = (!reN && !pins.chipEnableN) ? dOut : ~dOut;
endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the flash host sequencer against the device model
`timescale 1ns/1ps
module tb_top;
    import nrs_pkg::*;
    logic         clock, resetn, clockEnable, reqValid, wrValid, failInject;
    logic         reqReady, wrReady, rdValid, failFlag, done, readyBusyN;
    logic [7:0]   wrData, rdData, dataIn;
    logic [15:0]  byteCount;
    nrs_req_type  req;
    nrs_pins_type pins;
    int           errorCnt = 0;
    int           checksDone = 0;
    int           protoErrs;
    logic [7:0]   rxq [$];
    logic [7:0]   gold [int];

    nrs_host nrs_host_i (.clock(clock), .resetn(resetn), .clockEnable(clockEnable), .req(req),
        .reqValid(reqValid), .reqReady(reqReady), .wrData(wrData), .wrValid(wrValid), .wrReady(wrReady),
        .byteCount(byteCount), .rdData(rdData), .rdValid(rdValid), .failFlag(failFlag), .done(done),
        .pins(pins), .dataIn(dataIn), .readyBusyN(readyBusyN));
    nrs_flash_model #(.BUSY_CYC(20)) nrs_flash_model_i (.clock(clock), .pins(pins), .failInject(failInject),
        .dataIn(dataIn), .readyBusyN(readyBusyN), .protoErrs(protoErrs));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Collect read bytes; program data advances on every accepted byte
    always @(posedge clock) begin
        if (rdValid === 1'b1) rxq.push_back(rdData);
        if (wrValid && wrReady) wrData <= wrData + 8'h01;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
        checksDone++;
        if (seen !== want) begin
            errorCnt++;
            $display("BAD %0t %s seen %h want %h", $time, what, seen, want);
        end
    endtask

    task automatic close_out;
        if (errorCnt == 0 && checksDone > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    function automatic logic [7:0] want(input logic [17:0] r, input int c);
        int k;
        k = int'(r) * 8192 + c;
        return gold.exists(k) ? gold[k] : (r[7:0] ^ 8'(c) ^ 8'h5A);
    endfunction

    // One operation: hold the request until taken, then wait for done under a bound
    task automatic run_op(input nrs_op_type op, input logic [12:0] c, input logic [17:0] r1,
                          input logic [17:0] r2, input logic [15:0] cnt);
        int n;
        rxq.delete();
        req <= '{op, c, r1, r2};
        byteCount <= cnt;
        reqValid <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (!(reqReady === 1'b1 && readyBusyN === 1'b1) && n < 2000);
        reqValid <= 1'b0;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (done !== 1'b1 && n < 5000);
        check((n < 5000) ? 8'h01 : 8'h00, 8'h01, "operation finished");
    endtask

    task automatic check_rx(input logic [17:0] r, input int c0, input int cnt);
        check(8'(rxq.size()), 8'(cnt), "byte count");
        for (int i = 0; i < cnt && i < rxq.size(); i++) check(rxq[i], want(r, c0 + i), "read byte");
    endtask

    // Program a page, recording what the device should now hold
    task automatic t_program(input nrs_op_type op, input logic [17:0] r1, input logic [17:0] r2, input int cnt);
        wrData <= 8'hC0;
        wrValid <= 1'b1;
        run_op(op, 13'h0010, r1, r2, 16'(cnt));
        wrValid <= 1'b0;
        for (int i = 0; i < cnt; i++) gold[int'(r1) * 8192 + 16 + i] = 8'hC0 + 8'(i);
        for (int i = 0; i < cnt && op == OP_DUAL_PROGRAM; i++) gold[int'(r2) * 8192 + 16 + i] = 8'hC0 + 8'(cnt + i);
    endtask

    task automatic t_reads;
        run_op(OP_READ, 13'h0005, 18'h00143, 18'h00000, 16'h0006);
        check_rx(18'h00143, 5, 6);
        run_op(OP_CACHE_NEXT, 13'h0000, 18'h00143, 18'h00000, 16'h0004);
        check_rx(18'h00144, 0, 4);
        run_op(OP_CACHE_LAST, 13'h0000, 18'h00143, 18'h00000, 16'h0004);
        check_rx(18'h00145, 0, 4);
        check({7'h00, readyBusyN}, 8'h01, "ready after last cached page");
        run_op(OP_CACHE_NEXT, 13'h0002, 18'h00280, 18'h00000, 16'h0003);
        check_rx(18'h00280, 2, 3);
    endtask

    // Clock enable low must hold the data port, latch and strobe pins where they stand, then the read resumes intact
    task automatic t_freeze;
        nrs_pins_type held;
        fork
            run_op(OP_READ, 13'h0003, 18'h00081, 18'h00000, 16'h0004);
            begin
                repeat (12) @(posedge clock);
                clockEnable <= 1'b0;
                @(posedge clock);
                held = pins;
                repeat (4) @(posedge clock);
                check(pins.dataOut, held.dataOut, "data port frozen");
                check({pins.cle, pins.ale, pins.writeStrobeN, pins.outputStrobeN, reqReady, 3'h0},
                      {held.cle, held.ale, held.writeStrobeN, held.outputStrobeN, 1'b0, 3'h0}, "pins frozen");
                clockEnable <= 1'b1;
            end
        join
        check_rx(18'h00081, 3, 4);
    endtask

    task automatic t_programs;
        t_program(OP_PROGRAM, 18'h00200, 18'h00000, 5);
        run_op(OP_STATUS, 13'h0000, 18'h00000, 18'h00000, 16'h0001);
        check({7'h00, failFlag}, 8'h00, "pass after single program");
        run_op(OP_READ, 13'h000F, 18'h00200, 18'h00000, 16'h0007);
        check_rx(18'h00200, 15, 7);
        failInject <= 1'b1;
        t_program(OP_DUAL_PROGRAM, 18'h00089, 18'h000C9, 3);
        failInject <= 1'b0;
        run_op(OP_STATUS, 13'h0000, 18'h00000, 18'h00000, 16'h0001);
        check({7'h00, failFlag}, 8'h01, "fail after dual program");
        run_op(OP_DUAL_READ, 13'h0000, 18'h000C9, 18'h00089, 16'h0016);
        check_rx(18'h000C9, 0, 22);
        run_op(OP_RESET, 13'h0000, 18'h00000, 18'h00000, 16'h0000);
    endtask

    // Watchdog: all operations fit well inside this span
    initial begin
        repeat (60000) @(posedge clock);
        errorCnt++;
        close_out();
    end

    initial begin
        resetn = 1'b0;
        clockEnable = 1'b1;
        reqValid = 1'b0;
        wrValid = 1'b0;
        wrData = 8'h00;
        byteCount = 16'h0000;
        req = '0;
        failInject = 1'b0;
        repeat (3) @(posedge clock);
        check({pins.cle, pins.ale, pins.dataOe, done, rdValid, 3'h0}, 8'h00, "idle low pins in reset");
        check({pins.writeStrobeN, pins.outputStrobeN, pins.chipEnableN, pins.writeProtectN, reqReady, 3'h7},
              8'hFF, "idle high pins in reset");
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        t_reads();
        t_programs();
        t_freeze();
        check(8'(protoErrs), 8'h00, "pin protocol faults");
        close_out();
    end
endmodule
